// >>> include/hsp_params.svh
// Register indices, field positions, reset values and mode codes.
`ifndef HSP_PARAMS_SVH
`define HSP_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define HSP_IDX_DATA_BUF     12'h18C
`define HSP_IDX_RATE_DIV     12'h18D
`define HSP_IDX_CTRL         12'h1A0
`define HSP_IDX_STAT         12'h1A1

// Control register fields.
`define HSP_CTRL_STOP_EN     0
`define HSP_CTRL_MODE_LSB    4
`define HSP_CTRL_MODE_MSB    7

// Status register fields.
`define HSP_STAT_COLL        0
`define HSP_STAT_DONE        1
`define HSP_STAT_STOP_BUSY   2
`define HSP_STAT_XFER_BUSY   3
`define HSP_STAT_SCL_LVL     4
`define HSP_STAT_SDA_LVL     5

// Reset values.
`define HSP_RST_RATE_DIV     8'h00
`define HSP_RST_MODE         4'h0

// Operating select codes: SPI host uses codes up to this value.
`define HSP_MODE_SPI_HOST_MAX 4'h3
`define HSP_MODE_I2C_HOST    4'h8

// Serial clock half periods in one byte transfer.
`define HSP_XFER_HALVES      5'h10

`endif

// >>> include/hsp_pkg.sv
// Types shared by the serial port stop and bit-rate logic.
package hsp_pkg;

  typedef enum logic [2:0] {
    HSP_ST_IDLE     = 3'b000,
    HSP_ST_SDA_LOW  = 3'b001,
    HSP_ST_SCL_REL  = 3'b010,
    HSP_ST_SCL_HIGH = 3'b011,
    HSP_ST_SDA_REL  = 3'b100
  } hsp_stop_state_e;

  typedef logic [3:0] hsp_mode_t;
  typedef logic [7:0] hsp_byte_t;

endpackage : hsp_pkg

// >>> rtl/hsp_brg.sv
// Reload-and-count-down bit-rate generator.
`timescale 1ns/1ps
module hsp_brg #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Control.
  input  wire logic             load,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] reload,
  // Status.
  output logic                  expired,
  output logic      [WIDTH-1:0] count
);

  logic prescale;
  wire  tick      = run && prescale;
  wire  at_zero   = (count == '0);

  // The counter steps at half the clock rate, so one half period is
  // (reload + 1) * 2 clocks and a full period (reload + 1) * 4 clocks.
  always_ff @(posedge ref_clk)
  begin
    if (rst || load)
    begin
      prescale <= 1'b0;
    end
    else if (run)
    begin
      prescale <= ~prescale;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      count <= '0;
    end
    else if (load || (tick && at_zero))
    begin
      count <= reload;
    end
    else if (tick)
    begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      expired <= 1'b0;
    end
    else
    begin
      expired <= tick && at_zero && !load;
    end
  end

endmodule : hsp_brg

// >>> rtl/hsp_stop_arb.sv
// Host serial port: Stop collision detection, bit-rate timing, registers.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "hsp_params.svh"
module hsp_stop_arb (
  // Clock and reset.
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Two-wire bus pins.
  input  wire logic               scl_in,
  output logic                    scl_out,
  output logic                    scl_oe,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  // Four-wire serial clock pin.
  output logic                    sck_out,
  // Events and client address views.
  output logic                    bus_collision_flag,
  output logic                    serial_done_flag,
  output logic                    stop_enable,
  output hsp_pkg::hsp_mode_t      port_operating_select,
  output logic      [6:0]         client_addr7,
  output logic      [1:0]         client_addr10_hi,
  output hsp_pkg::hsp_byte_t      client_addr10_lo
);
  import hsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  hsp_byte_t       serial_data_buffer;
  hsp_byte_t       rate_divider_own_address;
  hsp_stop_state_e stop_state;
  hsp_stop_state_e next_stop_state;
  logic            xfer_active;
  logic [4:0]      xfer_halves;

  wire [9:0] reg_idx   = paddr[11:2];
  wire hit_buf   = (reg_idx == 10'(`HSP_IDX_DATA_BUF));
  wire hit_div   = (reg_idx == 10'(`HSP_IDX_RATE_DIV));
  wire hit_ctrl  = (reg_idx == 10'(`HSP_IDX_CTRL));
  wire hit_stat  = (reg_idx == 10'(`HSP_IDX_STAT));
  wire hit_any   = hit_buf || hit_div || hit_ctrl || hit_stat;
  wire setup_ph  = psel && !penable;
  wire wr_acc    = psel && penable && pready && pwrite && hit_any;
  wire wr_buf    = wr_acc && hit_buf;
  wire wr_div    = wr_acc && hit_div;
  wire wr_ctrl   = wr_acc && hit_ctrl;
  wire wr_stat   = wr_acc && hit_stat;

  wire stop_busy = (stop_state != HSP_ST_IDLE);

  wire [7:0] ctrl_rd = {port_operating_select, 3'h0, stop_enable};
  wire [7:0] stat_rd = {2'h0, sda_in, scl_in, xfer_active, stop_busy,
                        serial_done_flag, bus_collision_flag};
  wire [7:0] rd_mux  = hit_buf  ? serial_data_buffer :
                       hit_div  ? rate_divider_own_address :
                       hit_ctrl ? ctrl_rd :
                       hit_stat ? stat_rd : 8'h00;

  // Zero wait states: read data is captured in setup, write data and ready in access.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !hit_any;
      prdata  <= (setup_ph && !pwrite) ? {24'h00_0000, rd_mux}
                                        : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data buffer and divider / own-address register.

  // The buffer has no reset so that it powers up undefined.
  always_ff @(posedge ref_clk)
  begin
    if (wr_buf)
    begin
      serial_data_buffer <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rate_divider_own_address <= `HSP_RST_RATE_DIV;
    end
    else if (wr_div)
    begin
      rate_divider_own_address <= pwdata[7:0];
    end
  end

  // Client address views; unused divider bits are simply not routed.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      client_addr7     <= 7'h00;
      client_addr10_hi <= 2'h0;
      client_addr10_lo <= 8'h00;
    end
    else
    begin
      client_addr7     <= rate_divider_own_address[7:1];
      client_addr10_hi <= rate_divider_own_address[2:1];
      client_addr10_lo <= rate_divider_own_address;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit-rate generator sharing between Stop timing and byte clocking.

  wire i2c_host  = (port_operating_select == `HSP_MODE_I2C_HOST);
  wire spi_host  = (port_operating_select <= `HSP_MODE_SPI_HOST_MAX);
  wire host_mode = i2c_host || spi_host;

  logic brg_expired;
  logic brg_load;

  // Stop and byte exclude each other on the generator: a byte cannot start mid-Stop, nor a Stop mid-byte.
  wire xfer_start = wr_buf && host_mode && !xfer_active && !stop_busy;
  wire xfer_last  = xfer_active && brg_expired &&
                    (xfer_halves == `HSP_XFER_HALVES - 5'h01);
  wire stop_timed = (stop_state == HSP_ST_SCL_HIGH) ||
                    (stop_state == HSP_ST_SDA_REL);
  wire brg_run    = xfer_active || stop_timed;

  hsp_brg #(
    .WIDTH (8)
  ) u_brg (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (brg_load),
    .run     (brg_run),
    .reload  (rate_divider_own_address),
    .expired (brg_expired),
    .count   ()
  );

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      xfer_active <= 1'b0;
      xfer_halves <= 5'h00;
    end
    else if (xfer_start)
    begin
      xfer_active <= 1'b1;
      xfer_halves <= 5'h00;
    end
    else if (xfer_last)
    begin
      xfer_active <= 1'b0;
    end
    else if (xfer_active && brg_expired)
    begin
      xfer_halves <= xfer_halves + 5'h01;
    end
  end

  // The clock toggles at each expiry during a byte transfer and keeps its level when stopped.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sck_out <= 1'b0;
    end
    else if (xfer_active && brg_expired)
    begin
      sck_out <= ~sck_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stop condition sequencer with collision checks.

  wire stop_go   = wr_ctrl && pwdata[`HSP_CTRL_STOP_EN] && i2c_host &&
                   !stop_busy && !xfer_active;
  wire coll_scl  = (stop_state == HSP_ST_SCL_HIGH) && !scl_in;
  wire coll_sda  = (stop_state == HSP_ST_SDA_REL) && brg_expired &&
                   !sda_in;
  wire collision = coll_scl || coll_sda;
  wire stop_ok   = (stop_state == HSP_ST_SDA_REL) && brg_expired && sda_in;

  assign brg_load = xfer_start ||
                    ((stop_state == HSP_ST_SCL_REL) && scl_in) ||
                    ((stop_state == HSP_ST_SCL_HIGH) && brg_expired &&
                     scl_in);

  always_comb
  begin
    next_stop_state = stop_state;
    unique case (stop_state)
      HSP_ST_IDLE:
      begin
        if (stop_go)
        begin
          next_stop_state = HSP_ST_SDA_LOW;
        end
      end
      HSP_ST_SDA_LOW:
      begin
        if (!sda_in)
        begin
          next_stop_state = HSP_ST_SCL_REL;
        end
      end
      HSP_ST_SCL_REL:
      begin
        if (scl_in)
        begin
          next_stop_state = HSP_ST_SCL_HIGH;
        end
      end
      HSP_ST_SCL_HIGH:
      begin
        if (coll_scl)
        begin
          next_stop_state = HSP_ST_IDLE;
        end
        else if (brg_expired)
        begin
          next_stop_state = HSP_ST_SDA_REL;
        end
      end
      HSP_ST_SDA_REL:
      begin
        if (brg_expired)
        begin
          next_stop_state = HSP_ST_IDLE;
        end
      end
      default:
      begin
        next_stop_state = HSP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stop_state <= HSP_ST_IDLE;
    end
    else
    begin
      stop_state <= next_stop_state;
    end
  end

  // Line drive: the host pulls low only; a released line floats high.
  wire next_sda_oe = (next_stop_state == HSP_ST_SDA_LOW) ||
                     (next_stop_state == HSP_ST_SCL_REL) ||
                     (next_stop_state == HSP_ST_SCL_HIGH);
  wire next_scl_oe = (next_stop_state == HSP_ST_SDA_LOW) ||
                     (xfer_active && i2c_host && !sck_out &&
                      !xfer_last);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sda_oe  <= 1'b0;
      scl_oe  <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
    else
    begin
      sda_oe  <= next_sda_oe;
      scl_oe  <= next_scl_oe;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and status flags; a hardware set wins over a software clear.

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stop_enable           <= 1'b0;
      port_operating_select <= `HSP_RST_MODE;
    end
    else
    begin
      if (wr_ctrl)
      begin
        port_operating_select <=
          pwdata[`HSP_CTRL_MODE_MSB:`HSP_CTRL_MODE_LSB];
      end
      if (stop_go)
      begin
        stop_enable <= 1'b1;
      end
      else if (collision || stop_ok)
      begin
        stop_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bus_collision_flag <= 1'b0;
      serial_done_flag   <= 1'b0;
    end
    else
    begin
      if (collision)
      begin
        bus_collision_flag <= 1'b1;
      end
      else if (wr_stat && pwdata[`HSP_STAT_COLL])
      begin
        bus_collision_flag <= 1'b0;
      end
      if (stop_ok || xfer_last)
      begin
        serial_done_flag <= 1'b1;
      end
      else if (wr_stat && pwdata[`HSP_STAT_DONE])
      begin
        serial_done_flag <= 1'b0;
      end
    end
  end

endmodule : hsp_stop_arb

// >>> verif/hsp_bus_peer.sv
// Other bus parties: pull-ups plus a second host that can pull lines low.
`timescale 1ns/1ps
module hsp_bus_peer (
  // Design pin enables.
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // Bench commands to the other host.
  input  wire logic hold_scl,
  input  wire logic hold_sda,
  // Resolved wire levels.
  output logic      scl_line,
  output logic      sda_line
);
  // Wired AND with pull-ups; holding SCL low is how a slow party stretches.
  assign scl_line = !(scl_oe || hold_scl);
  assign sda_line = !(sda_oe || hold_sda);
endmodule : hsp_bus_peer

// >>> verif/hsp_stop_arb_chk.sv
// Port checker for the stop arbitration block.
`timescale 1ns/1ps
module hsp_stop_arb_chk (
  // Clock and reset.
  input wire logic               ref_clk,
  input wire logic               rst,
  // APB.
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  // Bus pins.
  input wire logic               scl_in,
  input wire logic               sda_in,
  input wire logic               scl_oe,
  input wire logic               sda_oe,
  input wire logic               scl_out,
  input wire logic               sda_out,
  input wire logic               sck_out,
  // Events and views.
  input wire logic               bus_collision_flag,
  input wire logic               serial_done_flag,
  input wire logic               stop_enable,
  input wire logic [6:0]         client_addr7,
  input wire logic [1:0]         client_addr10_hi,
  input wire hsp_pkg::hsp_byte_t client_addr10_lo
);
  import hsp_pkg::*;
  logic [15:0] hi_cnt;
  logic [15:0] half_cnt;
  logic        sck_q;
  logic [15:0] two_div;
  assign two_div = {7'h0, client_addr10_lo, 1'b0};
  always_ff @(posedge ref_clk)
  begin
    hi_cnt   <= (rst || !scl_in || scl_oe) ? 16'h0 : hi_cnt + 16'h1;
    half_cnt <= (rst || sck_out != sck_q) ? 16'h0 : half_cnt + 16'h1;
    sck_q    <= sck_out;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  setup_answer_a: assert property (psel && !penable |=> pready && penable)
    else $error("no answer after setup");
  answer_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("answer without setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error outside access");
  addr_views_a: assert property (
    client_addr7 == client_addr10_lo[7:1] &&
    client_addr10_hi == client_addr10_lo[2:1])
    else $error("address views wrong");
  drive_low_a: assert property (!scl_out && !sda_out)
    else $error("pin drives high");
  stop_order_a: assert property ($fell(scl_oe) && stop_enable |->
    sda_oe && !$past(sda_in))
    else $error("scl released before sda low");
  release_wait_a: assert property ($fell(sda_oe) && stop_enable &&
    !bus_collision_flag && $past(scl_in) |-> hi_cnt > two_div)
    else $error("sda released early");
  coll_release_a: assert property ($rose(bus_collision_flag) |->
    ##[0:1] !stop_enable && !sda_oe && !scl_oe)
    else $error("collision left lines held");
  stop_end_a: assert property ($fell(stop_enable) |-> ##[0:1]
    (bus_collision_flag || serial_done_flag) && !sda_oe && !scl_oe)
    else $error("stop end unflagged");
  clock_half_a: assert property (
    $changed(sck_out) |-> half_cnt > two_div)
    else $error("serial clock half too short");
  stop_done_c: cover property ($fell(stop_enable) && !bus_collision_flag);
  stop_coll_c: cover property ($rose(bus_collision_flag));
  sck_edge_c: cover property ($changed(sck_out));
endmodule : hsp_stop_arb_chk
bind hsp_stop_arb hsp_stop_arb_chk u_chk (.*);

// >>> verif/tb_top.sv
// Self-checking bench for the stop arbitration block.
`timescale 1ns/1ps
`include "hsp_params.svh"
module tb_top;
  import hsp_pkg::*;
  localparam int DIV = 3;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, hold_scl;
  logic hold_sda, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  logic sck_out, bus_collision_flag, serial_done_flag, stop_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr;
  logic [32:0] exp_q[$];
  logic [32:0] mon_e;
  hsp_mode_t   port_operating_select;
  logic [6:0]  client_addr7;
  logic [1:0]  client_addr10_hi;
  hsp_byte_t   client_addr10_lo;
  int          err_total, compares;
  hsp_stop_arb DUT (.*);
  hsp_bus_peer peer (.scl_oe, .sda_oe, .hold_scl, .hold_sda,
    .scl_line(scl_in), .sda_line(sda_in));
  always #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task automatic chk(string nm, logic [32:0] seen, logic [32:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic apb(logic w, logic [11:0] idx, logic [31:0] d,
                     logic [32:0] e);
    int n;
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[9:0], 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20) err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // Writes check only the response (OKAY or SLVERR); reads check data too.
  always @(posedge ref_clk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      mon_e = exp_q.pop_front();
      chk("apb", {pslverr, pwrite ? 32'h0 : prdata}, mon_e);
    end
  end
  task automatic byte_run(hsp_mode_t m, hsp_byte_t b);
    int tog, gap, n;
    logic last;
    apb(1, `HSP_IDX_CTRL, {24'h0, m, 4'h0}, 33'h0);
    chk("mode", 33'(port_operating_select), 33'(m));
    apb(1, `HSP_IDX_DATA_BUF, {24'h0, b}, 33'h0);
    tog = 0;
    gap = 0;
    n = 0;
    last = sck_out;
    while (serial_done_flag !== 1'b1 && n < 3000)
    begin
      @(posedge ref_clk);
      n++;
      gap++;
      if (sck_out !== last)
      begin
        tog++;
        if (tog > 1) chk("half", 33'(gap), 33'(2 * (DIV + 1)));
        gap = 0;
        last = sck_out;
      end
    end
    chk("toggles", 33'(tog), 33'd16);
    repeat (30) @(posedge ref_clk);
    chk("sck hold", sck_out, last);
    apb(0, `HSP_IDX_DATA_BUF, 0, {25'h0, b});
    apb(1, `HSP_IDX_STAT, 32'h2, 33'h0);
  endtask : byte_run
  task automatic stop_run(int kind);
    int n;
    hold_sda <= (kind == 1);
    hold_scl <= (kind == 0);
    apb(1, `HSP_IDX_CTRL, 32'h81, 33'h0);
    @(posedge ref_clk);
    n = 0;
    while (!(stop_enable === 1'b1 && scl_oe === 1'b0) && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("sda first", sda_oe, 1'b1);
    // Only the stretch case waits here; the SCL-low collision must be
    // injected while the counter still runs before SDA is released.
    if (kind == 0)
    begin
      repeat (20) @(posedge ref_clk);
      chk("stretch", sda_oe, 1'b1);
    end
    hold_scl <= 1'b0;
    if (kind == 2)
    begin
      repeat (3) @(posedge ref_clk);
      hold_scl <= 1'b1;
    end
    n = 0;
    while (stop_enable !== 1'b0 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    chk("coll", bus_collision_flag, kind != 0);
    chk("done", serial_done_flag, kind == 0);
    chk("lines", {sda_oe, scl_oe}, 2'b00);
    hold_sda <= 1'b0;
    hold_scl <= 1'b0;
    @(posedge ref_clk);
    apb(0, `HSP_IDX_STAT, 0,
        {27'h0, 2'b11, 2'b00, kind == 0, kind != 0});
    apb(1, `HSP_IDX_STAT, 32'h3, 33'h0);
    apb(0, `HSP_IDX_STAT, 0, 33'h30);
  endtask : stop_run
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
  initial
  begin
    {ref_clk, psel, penable, pwrite, hold_scl, hold_sda} = '0;
    {paddr, pwdata, err_total, compares} = '0;
    rst = 1'b1;
    lfsr = 32'hA663;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    apb(0, `HSP_IDX_RATE_DIV, 0, 33'h0);
    apb(0, 12'h001, 0, {1'b1, 32'h0});
    apb(1, 12'h001, 32'hFF, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      apb(1, `HSP_IDX_RATE_DIV, lfsr, 33'h0);
      apb(0, `HSP_IDX_RATE_DIV, 0, {25'h0, lfsr[7:0]});
      chk("addr7", 33'(client_addr7), 33'(lfsr[7:1]));
      chk("addr hi", 33'(client_addr10_hi), 33'(lfsr[2:1]));
      chk("addr lo", 33'(client_addr10_lo), 33'(lfsr[7:0]));
    end
    apb(1, `HSP_IDX_RATE_DIV, DIV, 33'h0);
    byte_run({2'b00, lfsr[1:0]}, lfsr[15:8]);
    byte_run(`HSP_MODE_I2C_HOST, lfsr[23:16]);
    for (int k = 0; k < 3; k++) stop_run(k);
    give_verdict();
  end
endmodule : tb_top
